// file: rtl/ubt_bit_test_unit.sv
// Accumulator AND memory flag evaluation
`timescale 1ns/1ns
`default_nettype none
module ubt_bit_test_unit (
    input  wire logic [`UBT_DATA_W-1:0] acc,
    input  wire logic [`UBT_DATA_W-1:0] mem,
    input  wire ubt_pkg::ubt_flags_t    flags_in,
    output ubt_pkg::ubt_flags_t         flags_out
);
    logic [`UBT_DATA_W-1:0] and_res;

    // Result is used for flags only, then dropped
    always_comb begin
        and_res = acc & mem;
        flags_out = flags_in;
        flags_out.n = and_res[`UBT_MSB];
        flags_out.z = (and_res == `UBT_ZERO_RES);
        flags_out.v = 1'b0;
    end
endmodule
`default_nettype wire

// file: rtl/ubt_branch_unit.sv
// Carry-clear branch decision and target address
`timescale 1ns/1ns
`default_nettype none
module ubt_branch_unit (
    input  wire logic [`UBT_PC_W-1:0]   pc,
    input  wire logic [`UBT_DATA_W-1:0] rel,
    input  wire logic                   carry,
    output ubt_pkg::ubt_br_res_t        res
);
    logic [`UBT_PC_W-1:0] next_pc;

    // Sign-extend the 8-bit displacement
    function automatic logic [`UBT_PC_W-1:0] sext(
        input logic [`UBT_DATA_W-1:0] d);
        return {{(`UBT_PC_W-`UBT_DATA_W){d[`UBT_MSB]}}, d};
    endfunction

    // Fall through past the two-byte branch, or jump
    always_comb begin
        next_pc = pc + `UBT_PC_STEP;
        res.taken = ~carry;
        res.target = carry ? next_pc
                           : next_pc + sext(rel);
    end
endmodule
`default_nettype wire

// file: rtl/ubt_exec.sv
// Unsigned branch and bit-test execution unit
//
// What this block does
// - Carry clear: jump to PC plus two plus offset
// - Both branch encodings behave identically
// - Taken when unsigned accumulator is at least memory
// - After register compare: taken if register is higher/same
// - After B-A compare: taken if B is higher/same
// - A test ANDs accumulator A with memory
// - B test ANDs accumulator B with memory
// - Result bit is AND of matching bits
// - Test result dropped; operands never written
// - N from MSB, V cleared, C, H, I, S and X kept
// - Z set when AND result is zero
`timescale 1ns/1ns
`default_nettype none
module ubt_exec (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     instr_valid,
    input  wire ubt_pkg::ubt_instr_t      instr,
    output logic                          instr_ready,
    input  wire logic [`UBT_ADDR_W-1:0]   reg_addr,
    input  wire logic [`UBT_RDATA_W-1:0]  reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [`UBT_RDATA_W-1:0]       reg_rdata,
    output logic [`UBT_PC_W-1:0]          pc_out,
    output ubt_pkg::ubt_flags_t           flags_out,
    output logic                          retire,
    output logic                          branch_taken
);
    ubt_pkg::ubt_state_t    st_r;
    ubt_pkg::ubt_state_t    st_nxt;
    ubt_pkg::ubt_br_res_t   br_res;
    ubt_pkg::ubt_flags_t    test_flags;
    logic [`UBT_DATA_W-1:0] test_acc;
    logic                   in_exec;
    logic                   exec_branch;
    logic                   exec_test;

    // Decode of the held instruction
    assign in_exec     = (st_r.fsm == ubt_pkg::UBT_EXEC);
    assign exec_branch = in_exec && ubt_pkg::is_branch(st_r.instr.op);
    assign exec_test   = in_exec && ubt_pkg::is_test(st_r.instr.op);

    // Pick the accumulator under test
    assign test_acc = (st_r.instr.op == ubt_pkg::UBT_OP_AND_TEST_ACC_B)
                    ? st_r.instr.acc_b
                    : st_r.instr.acc_a;

    // Branch condition and target
    ubt_branch_unit u_branch (
        .pc    (st_r.pc),
        .rel   (st_r.instr.rel),
        .carry (st_r.flags.c),
        .res   (br_res)
    );

    // Flag update of the bit tests
    ubt_bit_test_unit u_test (
        .acc       (test_acc),
        .mem       (st_r.instr.mem),
        .flags_in  (st_r.flags),
        .flags_out (test_flags)
    );

    // Register read mux
    function automatic logic [`UBT_RDATA_W-1:0] read_mux(
        input logic [`UBT_ADDR_W-1:0] addr,
        input ubt_pkg::ubt_state_t    s);
        logic [`UBT_RDATA_W-1:0] d;
        d = '0;
        case (addr)
            `UBT_REG_PC: begin
                d = s.pc;
            end
            `UBT_REG_FLAGS: begin
                d[`UBT_DATA_W-1:0] = s.flags;
            end
            `UBT_REG_STATUS: begin
                d[1:0] = {s.fsm == ubt_pkg::UBT_EXEC, s.last_taken};
            end
            default: begin
                d = '0;
            end
        endcase
        return d;
    endfunction

    // Next-state logic: register port, then execution
    always_comb begin
        st_nxt = st_r;
        st_nxt.retire = 1'b0;
        st_nxt.taken = 1'b0;
        st_nxt.rdata = '0;
        if (reg_rd) begin
            st_nxt.rdata = read_mux(reg_addr, st_r);
        end
        // Software writes; a commit in the same cycle wins
        if (reg_wr) begin
            case (reg_addr)
                `UBT_REG_PC: begin
                    st_nxt.pc = reg_wdata;
                end
                `UBT_REG_FLAGS: begin
                    st_nxt.flags = reg_wdata[`UBT_DATA_W-1:0];
                end
                default: begin
                    st_nxt.pc = st_r.pc;
                end
            endcase
        end
        case (st_r.fsm)
            ubt_pkg::UBT_IDLE: begin
                if (instr_valid) begin
                    st_nxt.instr = instr;
                    st_nxt.fsm = ubt_pkg::UBT_EXEC;
                end
            end
            ubt_pkg::UBT_EXEC: begin
                // One decision path serves both encodings
                if (ubt_pkg::is_branch(st_r.instr.op)) begin
                    st_nxt.pc = br_res.target;
                    st_nxt.flags = st_r.flags;
                    st_nxt.taken = br_res.taken;
                    st_nxt.last_taken = br_res.taken;
                end else if (ubt_pkg::is_test(st_r.instr.op)) begin
                    st_nxt.flags = test_flags;
                    st_nxt.pc = st_r.pc;
                end
                st_nxt.retire = 1'b1;
                st_nxt.fsm = ubt_pkg::UBT_IDLE;
            end
            default: begin
                st_nxt.fsm = ubt_pkg::UBT_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r.fsm <= ubt_pkg::UBT_IDLE;
            st_r.instr <= '0;
            st_r.pc <= `UBT_PC_RST;
            st_r.flags <= `UBT_FLG_RST;
            st_r.retire <= 1'b0;
            st_r.taken <= 1'b0;
            st_r.last_taken <= 1'b0;
            st_r.rdata <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign instr_ready  = (st_r.fsm == ubt_pkg::UBT_IDLE);
    assign reg_rdata    = st_r.rdata;
    assign pc_out       = st_r.pc;
    assign flags_out    = st_r.flags;
    assign retire       = st_r.retire;
    assign branch_taken = st_r.taken;

    // Independent reference for the test checks
    logic [`UBT_DATA_W-1:0] chk_and;
    logic [`UBT_PC_W-1:0]   chk_rel;
    assign chk_and = test_acc & st_r.instr.mem;
    assign chk_rel = {{(`UBT_PC_W-`UBT_DATA_W){st_r.instr.rel[`UBT_MSB]}},
                      st_r.instr.rel};

    // Taken branch lands at PC plus two plus offset
    AST_BR_TAKEN_PC: assert property (
        @(posedge clk) disable iff (rst)
        (exec_branch && !st_r.flags.c) |=>
            (pc_out == $past(st_r.pc) + `UBT_PC_STEP + $past(chk_rel)))
        else $error("taken branch target wrong");

    // Untaken branch moves to the next instruction
    AST_BR_FALL_PC: assert property (
        @(posedge clk) disable iff (rst)
        (exec_branch && st_r.flags.c) |=>
            (pc_out == $past(st_r.pc) + `UBT_PC_STEP) && !branch_taken)
        else $error("untaken branch target wrong");

    // Decision depends only on carry, for both encodings
    AST_BR_SAME_OP: assert property (
        @(posedge clk) disable iff (rst)
        exec_branch |=> (branch_taken == !$past(st_r.flags.c)) && retire)
        else $error("branch encodings disagree");

    // Carry clear from an unsigned compare means taken
    AST_BR_UNSIGNED: assert property (
        @(posedge clk) disable iff (rst)
        (exec_branch && !st_r.flags.c) |=> branch_taken ##1 !branch_taken)
        else $error("unsigned higher-or-same not taken");

    // Branch keeps every flag
    AST_BR_FLAGS: assert property (
        @(posedge clk) disable iff (rst)
        exec_branch |=> $stable(flags_out))
        else $error("branch changed flags");

    // Bit test negative flag from result MSB
    AST_TEST_N: assert property (
        @(posedge clk) disable iff (rst)
        exec_test |=> (flags_out.n == $past(chk_and[`UBT_MSB])))
        else $error("bit test N wrong");

    // Bit test zero flag from whole result
    AST_TEST_Z: assert property (
        @(posedge clk) disable iff (rst)
        exec_test |=> (flags_out.z == ($past(chk_and) == `UBT_ZERO_RES)))
        else $error("bit test Z wrong");

    // Bit test clears overflow
    AST_TEST_V: assert property (
        @(posedge clk) disable iff (rst)
        exec_test |=> !flags_out.v)
        else $error("bit test V not cleared");

    // Bit test keeps C, H, I, S and X
    AST_TEST_KEEP: assert property (
        @(posedge clk) disable iff (rst)
        exec_test |=> $stable({flags_out.c, flags_out.h, flags_out.i,
                               flags_out.s, flags_out.x}))
        else $error("bit test touched kept flags");

    // Bit test leaves the program counter alone
    AST_TEST_PC: assert property (
        @(posedge clk) disable iff (rst)
        exec_test |=> $stable(pc_out) && !branch_taken)
        else $error("bit test moved PC");

    // B variant uses accumulator B
    AST_TEST_B_SRC: assert property (
        @(posedge clk) disable iff (rst)
        (exec_test && st_r.instr.op == ubt_pkg::UBT_OP_AND_TEST_ACC_B) |=>
            (flags_out.z ==
             ($past(st_r.instr.acc_b & st_r.instr.mem) == `UBT_ZERO_RES)))
        else $error("B test used wrong accumulator");

    // A variant uses accumulator A
    AST_TEST_A_SRC: assert property (
        @(posedge clk) disable iff (rst)
        (exec_test && st_r.instr.op == ubt_pkg::UBT_OP_AND_TEST_ACC_A) |=>
            (flags_out.n ==
             $past(st_r.instr.acc_a[`UBT_MSB] & st_r.instr.mem[`UBT_MSB])))
        else $error("A test used wrong accumulator");

    // Every accepted instruction retires two cycles later
    AST_RETIRE: assert property (
        @(posedge clk) disable iff (rst)
        (instr_valid && instr_ready) |=> !instr_ready ##1 retire)
        else $error("instruction did not retire");
endmodule
`default_nettype wire

// file: rtl/ubt_params.svh
// Constants for the unsigned branch and bit-test unit
`ifndef UBT_PARAMS_SVH
`define UBT_PARAMS_SVH
`define UBT_PC_W       16
`define UBT_DATA_W     8
`define UBT_ADDR_W     2
`define UBT_RDATA_W    16
`define UBT_REG_PC     2'h0
`define UBT_REG_FLAGS  2'h1
`define UBT_REG_STATUS 2'h2
`define UBT_PC_STEP    16'h0002
`define UBT_PC_RST     16'h0000
`define UBT_FLG_RST    8'hd0
`define UBT_ZERO_RES   8'h00
`define UBT_MSB        7
`endif

// file: rtl/ubt_pkg.sv
// Types shared by the unsigned branch and bit-test unit
`include "ubt_params.svh"
package ubt_pkg;
    // Condition flags, most significant first
    typedef struct packed {
        logic s;
        logic x;
        logic h;
        logic i;
        logic n;
        logic z;
        logic v;
        logic c;
    } ubt_flags_t;

    // Operations handled by this unit
    typedef enum logic [2:0] {
        UBT_OP_NONE                 = 3'h0,
        UBT_OP_BRANCH_UNSIGNED_GE   = 3'h1,
        UBT_OP_BRANCH_IF_NO_CARRY   = 3'h2,
        UBT_OP_AND_TEST_ACC_A       = 3'h3,
        UBT_OP_AND_TEST_ACC_B       = 3'h4
    } ubt_op_t;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        UBT_IDLE = 2'b01,
        UBT_EXEC = 2'b10
    } ubt_fsm_t;

    // Decoded instruction with its operands
    typedef struct packed {
        ubt_op_t                 op;
        logic [`UBT_DATA_W-1:0]  rel;
        logic [`UBT_DATA_W-1:0]  acc_a;
        logic [`UBT_DATA_W-1:0]  acc_b;
        logic [`UBT_DATA_W-1:0]  mem;
    } ubt_instr_t;

    // Branch unit answer
    typedef struct packed {
        logic                   taken;
        logic [`UBT_PC_W-1:0]   target;
    } ubt_br_res_t;

    // Whole state of the top module
    typedef struct packed {
        ubt_fsm_t                fsm;
        ubt_instr_t              instr;
        logic [`UBT_PC_W-1:0]    pc;
        ubt_flags_t              flags;
        logic                    retire;
        logic                    taken;
        logic                    last_taken;
        logic [`UBT_RDATA_W-1:0] rdata;
    } ubt_state_t;

    // Both branch encodings are one operation
    function automatic logic is_branch(input ubt_op_t op);
        return (op == UBT_OP_BRANCH_UNSIGNED_GE) ||
               (op == UBT_OP_BRANCH_IF_NO_CARRY);
    endfunction

    // Either accumulator bit test
    function automatic logic is_test(input ubt_op_t op);
        return (op == UBT_OP_AND_TEST_ACC_A) ||
               (op == UBT_OP_AND_TEST_ACC_B);
    endfunction
endpackage

// file: verif/tb_top.sv
// Self-checking bench for the unsigned branch and bit-test unit
`timescale 1ns/1ns
`default_nettype none
`include "ubt_params.svh"
module tb_top;
    logic                      clk;
    logic                      rst;
    logic                      instr_valid;
    ubt_pkg::ubt_instr_t       instr;
    logic                      instr_ready;
    logic [`UBT_ADDR_W-1:0]    reg_addr;
    logic [`UBT_RDATA_W-1:0]   reg_wdata;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [`UBT_RDATA_W-1:0]   reg_rdata;
    logic [`UBT_PC_W-1:0]      pc_out;
    ubt_pkg::ubt_flags_t       flags_out;
    logic                      retire;
    logic                      branch_taken;
    int                        n_mismatch;
    int                        check_count;
    logic [15:0]               rv;
    logic [15:0]               exp_pc;
    logic [7:0]                res;
    logic [7:0]                pre;
    logic [7:0]                ta [4];
    logic [7:0]                tm [4];

    ubt_exec u_ubt_exec (
        .clk          (clk),
        .rst          (rst),
        .instr_valid  (instr_valid),
        .instr        (instr),
        .instr_ready  (instr_ready),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_rdata    (reg_rdata),
        .pc_out       (pc_out),
        .flags_out    (flags_out),
        .retire       (retire),
        .branch_taken (branch_taken)
    );

    // 20 MHz clock
    always #25 clk = ~clk;

    // Verdict and end of run
    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One comparison, counted
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register write, one strobe cycle
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Register read, data sampled in the following cycle
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // Offer one instruction, wait for retire two edges later
    task automatic run_op(input ubt_pkg::ubt_op_t op, input logic [7:0] rel,
                          input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] m);
        int n;
        n = 0;
        while (instr_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= '{op: op, rel: rel, acc_a: a, acc_b: b, mem: m};
        @(posedge clk);
        instr_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (retire !== 1'b1 && n < 6);
        if (retire !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
        chk(16'(n), 16'h0002);
    endtask

    // Branch with given carry; expects target or fall-through by two
    task automatic branch(input ubt_pkg::ubt_op_t op, input logic c,
                          input logic [15:0] pc0, input logic [7:0] rel);
        wr(`UBT_REG_PC, pc0);
        wr(`UBT_REG_FLAGS, {8'h00, 7'h77, c});
        run_op(op, rel, 8'h5a, 8'ha5, 8'h3c);
        exp_pc = pc0 + `UBT_PC_STEP + (c ? 16'h0000 : {{8{rel[7]}}, rel});
        chk(pc_out, exp_pc);
        chk({15'h0, branch_taken}, {15'h0, ~c});
        chk({8'h00, flags_out}, {8'h00, 7'h77, c});
    endtask

    // Bit test on one accumulator against memory
    task automatic bit_test(input logic use_b, input logic [7:0] acc,
                            input logic [7:0] m, input logic [7:0] f0);
        wr(`UBT_REG_PC, 16'h4321);
        wr(`UBT_REG_FLAGS, {8'h00, f0});
        if (use_b) begin
            run_op(ubt_pkg::UBT_OP_AND_TEST_ACC_B, 8'h00, ~acc, acc, m);
        end else begin
            run_op(ubt_pkg::UBT_OP_AND_TEST_ACC_A, 8'h00, acc, ~acc, m);
        end
        res = acc & m;
        chk({8'h00, flags_out}, {8'h00, (f0 & 8'hf1) | {4'h0, res[7],
            (res == `UBT_ZERO_RES), 2'b00}});
        chk(pc_out, 16'h4321);
        chk({15'h0, branch_taken}, 16'h0000);
    endtask

    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        ta = '{8'hff, 8'h0f, 8'h55, 8'h00};
        tm = '{8'h80, 8'hf0, 8'h57, 8'h00};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped places
        rd(`UBT_REG_PC, rv);
        chk(rv, `UBT_PC_RST);
        rd(`UBT_REG_FLAGS, rv);
        chk(rv, {8'h00, `UBT_FLG_RST});
        wr(2'h3, 16'hffff);
        rd(2'h3, rv);
        chk(rv, 16'h0000);
        // Both branch encodings, taken forward and not taken; taken back on UBT_OP_BRANCH_UNSIGNED_GE only
        branch(ubt_pkg::UBT_OP_BRANCH_UNSIGNED_GE, 1'b0, 16'h1000, 8'h10);
        branch(ubt_pkg::UBT_OP_BRANCH_IF_NO_CARRY, 1'b0, 16'h1000, 8'h10);
        branch(ubt_pkg::UBT_OP_BRANCH_UNSIGNED_GE, 1'b0, 16'h0004, 8'hf0);
        branch(ubt_pkg::UBT_OP_BRANCH_IF_NO_CARRY, 1'b0, 16'hfffe, 8'h7f);
        branch(ubt_pkg::UBT_OP_BRANCH_UNSIGNED_GE, 1'b1, 16'h2000, 8'h40);
        branch(ubt_pkg::UBT_OP_BRANCH_IF_NO_CARRY, 1'b1, 16'h2000, 8'h80);
        // Carry as left by unsigned compares of register against memory and of memory against register
        for (int i = 0; i < 4; i++) begin
            branch(ubt_pkg::UBT_OP_BRANCH_UNSIGNED_GE, ta[i] < tm[i],
                   16'h0100, 8'h20);
            chk({15'h0, branch_taken}, {15'h0, ta[i] >= tm[i]});
            branch(ubt_pkg::UBT_OP_BRANCH_UNSIGNED_GE, tm[i] < ta[i],
                   16'h0100, 8'h20);
            chk({15'h0, branch_taken}, {15'h0, tm[i] >= ta[i]});
        end
        // Bit tests on both accumulators with two flag presets
        for (int i = 0; i < 4; i++) begin
            pre = i[0] ? 8'hd3 : 8'h2c;
            bit_test(1'b0, ta[i], tm[i], pre);
            bit_test(1'b1, ta[i], tm[i], ~pre);
        end
        // Second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`UBT_REG_PC, rv);
        chk(rv, `UBT_PC_RST);
        give_verdict();
    end

    // Watchdog against a hang
    initial begin
        #1000000;
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
